// file: verification/asp_pin_model.sv
// pin level model for the port: external drivers meet the port drivers
`timescale 1ns/10ps

module asp_pin_model (
  // port side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  // far side
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  // ----------------------------------------------------------------
  // wire resolution: a driving port pin wins, else the external level
  // ----------------------------------------------------------------
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

// file: verification/testbench.sv
// self-checking bench for the analog shared io port
`timescale 1ns/10ps
`include "asp_cfg.svh"

module testbench;
  import asp_pkg::*;
  localparam logic [11:0] latch_a = {`ASP_LATCH_IDX, 2'b00};
  localparam logic [11:0] dir_a = {`ASP_DIR_IDX, 2'b00};
  localparam logic [11:0] conv_a = {`ASP_CONV_IDX, 2'b00};
  localparam logic [11:0] mode_a = {`ASP_MODE_IDX, 2'b00};
  localparam logic [11:0] bad_a = 12'h040;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic [7:0] ext_val = 8'hff;
  logic [7:0] analog_select;
  logic analog_input_disable;
  asp_sec_t sec_in;
  int error_cnt = 0;
  int checks = 0;
  logic [31:0] rd;
  logic er;

  always #50 pclk = ~pclk;

  asp_port dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .analog_input_disable(analog_input_disable),
    .analog_select(analog_select), .sec_in(sec_in)
  );

  asp_pin_model pins_u (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .pin_in(pin_in)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 4'h1);
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [7:0] e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(nm, {24'h0, e}, rd);
    chk("pslverr", 32'h0, {31'h0, er});
  endtask

  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    ext_val <= 8'hff;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    chk("pin_oe", 32'h0, {24'h0, pin_oe});
    chk("pin_out", 32'h0, {24'h0, pin_out});
    chk("disable", 32'h1, {31'h0, analog_input_disable});
    chk("analog_select", 32'h0, {24'h0, analog_select});
    chk("sec_in", 32'h0, {25'h0, sec_in});
    chk("pready", 32'h1, {31'h0, pready});
    rdchk("latch", latch_a, 8'h00);
    rdchk("dir", dir_a, 8'h00);
    rdchk("conv", conv_a, 8'h01);
  endtask

  task automatic t_input();
    wr(latch_a, 8'hff);
    ext_val <= 8'ha5;
    settle();
    rdchk("latch in", latch_a, 8'ha5);
    chk("sec_in", 32'h52, {25'h0, sec_in});
  endtask

  task automatic t_output();
    wr(dir_a, 8'h0f);
    wr(latch_a, 8'h3c);
    @(negedge pclk);
    chk("pin_out", 32'h3c, {24'h0, pin_out});
    chk("pin_oe", 32'h0f, {24'h0, pin_oe});
    settle();
    rdchk("latch mix", latch_a, 8'h2c);
    chk("analog_select", 32'h0, {24'h0, analog_select});
  endtask

  task automatic t_analog();
    ext_val <= 8'hff;
    wr(dir_a, 8'h03);
    wr(latch_a, 8'hf0);
    wr(conv_a, 8'h00);
    @(negedge pclk);
    chk("disable", 32'h0, {31'h0, analog_input_disable});
    chk("analog_select", 32'h0c, {24'h0, analog_select});
    chk("pin_out", 32'hf0, {24'h0, pin_out});
    settle();
    rdchk("mode", mode_a, 8'h0c);
    rdchk("latch an", latch_a, 8'hf0);
    chk("sec_in", 32'h78, {25'h0, sec_in});
  endtask

  task automatic t_bus();
    apb(1'b0, bad_a, 32'h0, 4'h0);
    chk("bad rd", 32'h0, rd);
    chk("bad err", 32'h1, {31'h0, er});
    apb(1'b1, bad_a, 32'hff, 4'h1);
    chk("bad wr err", 32'h1, {31'h0, er});
    apb(1'b1, dir_a, 32'hff, 4'h0);
    rdchk("dir strb", dir_a, 8'h03);
    wr(mode_a, 8'hff);
    chk("mode wr err", 32'h0, {31'h0, er});
    rdchk("mode ro", mode_a, 8'h0c);
  endtask

  // ----------------------------------------------------------------
  // end of run
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    stop_test();
  end

  initial begin
    t_reset();
    t_input();
    t_output();
    t_analog();
    t_bus();
    t_reset();
    stop_test();
  end
endmodule

// file: verilog/asp_cfg.svh
// offsets, field positions, reset values of the analog shared io port
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define ASP_NPINS 8
`define ASP_PADDR_W 12

// ----------------------------------------------------------------
// register indices (byte address is index times four)
// ----------------------------------------------------------------
`define ASP_LATCH_IDX 10'h006
`define ASP_DIR_IDX 10'h00c
`define ASP_CONV_IDX 10'h00e
`define ASP_MODE_IDX 10'h00f

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ASP_DISABLE_BIT 0
`define ASP_KEY_WAKE_LO 4
`define ASP_EXT_INT_BIT 3
`define ASP_EVT_CNT_BIT 2
`define ASP_EVT_CLK_BIT 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ASP_LATCH_RST 8'h00
`define ASP_DIR_RST 8'h00
`define ASP_DISABLE_RST 1'b1

`endif

// file: verilog/asp_pkg.sv
// types shared by the analog shared io port
package asp_pkg;

  // ----------------------------------------------------------------
  // per-pin mode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    asp_mode_forced_zero,
    asp_mode_digital_in,
    asp_mode_digital_out,
    asp_mode_analog_in
  } asp_mode_t;

  // ----------------------------------------------------------------
  // levels handed to interrupt, counter and key wake-up logic
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] key_wake;
    logic external_interrupt_zero;
    logic event_counter_input;
    logic event_clock_input;
  } asp_sec_t;

endpackage

// file: verilog/asp_port.sv
// eight pin port shared between digital io and converter inputs
`timescale 1ns/10ps
`include "asp_cfg.svh"

module asp_port (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ASP_PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // port pins
  input wire logic [`ASP_NPINS-1:0] pin_in,
  output logic [`ASP_NPINS-1:0] pin_out,
  output logic [`ASP_NPINS-1:0] pin_oe,
  // converter side
  output logic analog_input_disable,
  output logic [`ASP_NPINS-1:0] analog_select,
  // secondary function inputs
  output asp_pkg::asp_sec_t sec_in
);
  import asp_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [`ASP_NPINS-1:0] port_output_latch;
  logic [`ASP_NPINS-1:0] next_port_output_latch;
  logic [`ASP_NPINS-1:0] port_direction_control;
  logic [`ASP_NPINS-1:0] next_port_direction_control;
  logic next_analog_input_disable;
  logic [`ASP_NPINS-1:0] next_analog_select;
  logic [`ASP_NPINS-1:0] pin_meta;
  logic [`ASP_NPINS-1:0] pin_sync;
  logic [`ASP_NPINS-1:0] in_val;
  logic [`ASP_NPINS-1:0] ana_mask;
  asp_sec_t next_sec_in;
  logic [31:0] next_prdata;
  logic err;
  logic next_err;
  logic setup;
  logic access;
  logic wr;
  logic unmapped;
  logic out_of_reset;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic asp_mode_t pin_mode(input logic dir, input logic lat,
                                         input logic dis);
    if (dir) begin
      pin_mode = asp_mode_digital_out;
    end else if (lat) begin
      pin_mode = asp_mode_digital_in;
    end else if (dis) begin
      pin_mode = asp_mode_forced_zero;
    end else begin
      pin_mode = asp_mode_analog_in;
    end
  endfunction

  function automatic logic seen_level(input asp_mode_t m, input logic lvl);
    case (m)
      asp_mode_digital_in: seen_level = lvl;
      asp_mode_digital_out: seen_level = lvl;
      default: seen_level = 1'b0;
    endcase
  endfunction

  function automatic logic hit(input logic [`ASP_PADDR_W-1:0] a,
                               input logic [9:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < `ASP_NPINS; i++) begin
      ana_mask[i] = (pin_mode(port_direction_control[i],
                              port_output_latch[i],
                              analog_input_disable) == asp_mode_analog_in);
      in_val[i] = seen_level(pin_mode(port_direction_control[i],
                                      port_output_latch[i],
                                      analog_input_disable), pin_sync[i]);
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite & pready & pstrb[0];
  assign unmapped = ~(hit(paddr, `ASP_LATCH_IDX) | hit(paddr, `ASP_DIR_IDX) |
                      hit(paddr, `ASP_CONV_IDX) | hit(paddr, `ASP_MODE_IDX));
  assign pready = 1'b1;
  assign pslverr = access & err;

  // ----------------------------------------------------------------
  // register next values
  // ----------------------------------------------------------------
  always_comb begin
    next_port_output_latch = port_output_latch;
    next_port_direction_control = port_direction_control;
    next_analog_input_disable = analog_input_disable;
    next_prdata = prdata;
    next_err = err;
    if (wr && hit(paddr, `ASP_LATCH_IDX)) begin
      next_port_output_latch = pwdata[`ASP_NPINS-1:0];
    end
    if (wr && hit(paddr, `ASP_DIR_IDX)) begin
      next_port_direction_control = pwdata[`ASP_NPINS-1:0];
    end
    if (wr && hit(paddr, `ASP_CONV_IDX)) begin
      next_analog_input_disable = pwdata[`ASP_DISABLE_BIT];
    end
    if (setup) begin
      next_err = unmapped;
      next_prdata = 32'h0000_0000;
      if (!pwrite) begin
        if (hit(paddr, `ASP_LATCH_IDX)) begin
          next_prdata[`ASP_NPINS-1:0] = in_val;
        end
        if (hit(paddr, `ASP_DIR_IDX)) begin
          next_prdata[`ASP_NPINS-1:0] = port_direction_control;
        end
        if (hit(paddr, `ASP_CONV_IDX)) begin
          next_prdata[`ASP_DISABLE_BIT] = analog_input_disable;
        end
        if (hit(paddr, `ASP_MODE_IDX)) begin
          next_prdata[`ASP_NPINS-1:0] = ana_mask;
        end
      end
    end
    for (int i = 0; i < `ASP_NPINS; i++) begin
      next_analog_select[i] = (pin_mode(next_port_direction_control[i],
                                        next_port_output_latch[i],
                                        next_analog_input_disable)
                               == asp_mode_analog_in);
    end
    next_sec_in.key_wake = in_val[`ASP_NPINS-1:`ASP_KEY_WAKE_LO];
    next_sec_in.external_interrupt_zero = in_val[`ASP_EXT_INT_BIT];
    next_sec_in.event_counter_input = in_val[`ASP_EVT_CNT_BIT];
    next_sec_in.event_clock_input = in_val[`ASP_EVT_CLK_BIT];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_output_latch <= `ASP_LATCH_RST;
      port_direction_control <= `ASP_DIR_RST;
      analog_input_disable <= `ASP_DISABLE_RST;
      analog_select <= '0;
      sec_in <= '0;
      prdata <= 32'h0000_0000;
      err <= 1'b0;
      out_of_reset <= 1'b0;
    end else begin
      port_output_latch <= next_port_output_latch;
      port_direction_control <= next_port_direction_control;
      analog_input_disable <= next_analog_input_disable;
      analog_select <= next_analog_select;
      sec_in <= next_sec_in;
      prdata <= next_prdata;
      err <= next_err;
      out_of_reset <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  assign pin_out = port_output_latch;
  assign pin_oe = port_direction_control;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_reset_values;
    @(posedge pclk) disable iff (!presetn)
    !out_of_reset |-> (port_direction_control == 8'h00 &&
                       port_output_latch == 8'h00 && analog_input_disable &&
                       pin_oe == 8'h00 && analog_select == 8'h00);
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("register values after reset are wrong");

  property p_dir_write;
    @(posedge pclk) disable iff (!presetn)
    (access && pwrite && pstrb[0] && hit(paddr, `ASP_DIR_IDX))
    |=> pin_oe == $past(pwdata[7:0]);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write did not reach the output enables");

  property p_latch_write;
    @(posedge pclk) disable iff (!presetn)
    (setup && pwrite && hit(paddr, `ASP_LATCH_IDX))
    ##1 (access && pstrb[0])
    |-> $stable(pin_out) ##1 pin_out == $past(pwdata[7:0]);
  endproperty
  a_latch_write: assert property (p_latch_write)
    else $error("latch write changed the pins at the wrong edge");

  property p_drive;
    @(posedge pclk) disable iff (!presetn)
    (pin_oe == port_direction_control) && (pin_out == port_output_latch) &&
    ((pin_oe & analog_select) == 8'h00);
  endproperty
  a_drive: assert property (p_drive)
    else $error("pin drive does not follow direction and latch");

  property p_analog_sel;
    @(posedge pclk) disable iff (!presetn)
    analog_select == (~port_direction_control & ~port_output_latch &
                      {8{~analog_input_disable}});
  endproperty
  a_analog_sel: assert property (p_analog_sel)
    else $error("analog selection does not match the mode bits");

  property p_read_analog_zero;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit(paddr, `ASP_LATCH_IDX))
    |=> (prdata[7:0] & $past(analog_select)) == 8'h00;
  endproperty
  a_read_analog_zero: assert property (p_read_analog_zero)
    else $error("analog bit did not read as zero");

  property p_read_level;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit(paddr, `ASP_LATCH_IDX))
    |=> ((prdata[7:0] ^ $past(pin_sync)) &
         ($past(port_output_latch) | $past(port_direction_control)))
        == 8'h00;
  endproperty
  a_read_level: assert property (p_read_level)
    else $error("latch read did not return the sampled pin level");

  property p_read_dir;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit(paddr, `ASP_DIR_IDX))
    |=> prdata == {24'h000000, $past(port_direction_control)};
  endproperty
  a_read_dir: assert property (p_read_dir)
    else $error("direction read back is wrong");

  property p_forced_zero;
    @(posedge pclk) disable iff (!presetn)
    (!port_direction_control[3] && !port_output_latch[3])
    |=> !sec_in.external_interrupt_zero;
  endproperty
  a_forced_zero: assert property (p_forced_zero)
    else $error("forced pin reached the interrupt input");

  property p_sec_follow;
    @(posedge pclk) disable iff (!presetn)
    (port_output_latch[7] && !port_direction_control[7])
    |=> sec_in.key_wake[3] == $past(pin_sync[7]);
  endproperty
  a_sec_follow: assert property (p_sec_follow)
    else $error("key wake input does not follow the pin");

  property p_digital_kept;
    @(posedge pclk) disable iff (!presetn)
    (!analog_input_disable && port_output_latch[0])
    |-> !analog_select[0];
  endproperty
  a_digital_kept: assert property (p_digital_kept)
    else $error("latched pin became analog while converter in use");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
    (setup && unmapped) |=> (access |-> pslverr);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access gave no error");

  property p_conv_write;
    @(posedge pclk) disable iff (!presetn)
    (access && pwrite && pstrb[0] && hit(paddr, `ASP_CONV_IDX))
    |=> analog_input_disable == $past(pwdata[`ASP_DISABLE_BIT]);
  endproperty
  a_conv_write: assert property (p_conv_write)
    else $error("converter disable write did not take effect");

  property p_digital_level;
    @(posedge pclk) disable iff (!presetn)
    (!analog_input_disable && port_output_latch[4] &&
     !port_direction_control[4])
    |=> sec_in.key_wake[0] == $past(pin_sync[4]);
  endproperty
  a_digital_level: assert property (p_digital_level)
    else $error("latched pin lost its digital input with converter on");

endmodule
